/* logic/hsp_port.sv */
// Host serial register port: SPI (full or half duplex) or I2C slave
`timescale 1ns/100ps
// Summary of operation
// RQ1 - Interface select pin low picks SPI, high picks I2C.
// RQ2 - Both interfaces use the same register access port, so all registers.
// RQ3 - SPI works full and half duplex up to the maximum clock rate; the code samples SCLK on the 10 MHz system clock, too slow for 12 MHz.
// RQ4 - SPI starts full duplex; half duplex after software sets the mode bit.
// RQ5 - Host runs SPI mode 0: clock idles low, sampling on rising edge.
// RQ6 - SPI is ignored while either supply is below its threshold.
// RQ7 - Full duplex: select pin is SS, serial-in is MOSI, serial-out is MISO.
// RQ8 - Half duplex: host grounds serial-in and uses an open-drain MOSI.
// RQ9 - Half-duplex writes use the full-duplex write frame unchanged.
// RQ10 - Half-duplex read: command on shared pin, then device drives 8 bits.
// RQ11 - I2C runs Fast Mode Plus up to its maximum clock rate.
// RQ12 - I2C supports single and burst register reads and writes.
// RQ13 - I2C address is fixed upper five bits plus two strap bits.
// RQ14 - First I2C byte is seven address bits then direction, 1 reads.
// RQ15 - The byte after any START is taken as the address byte.
// RQ16 - Write: START, address, ACK, register, ACK, data, ACK, STOP.
// RQ17 - Register address is ACKed only when valid, otherwise NACKed.
// RQ18 - One I2C write carries one or two data bytes.
// RQ19 - SPI frame under select low: command byte then data byte, MSB first.
// RQ20 - In I2C mode the strap pins are static levels, not SPI inputs.
module hsp_port
  import hsp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       iface_sel_pin,
  input  wire logic       sclk_pin,
  input  wire logic       select_addr_bit0_pin,
  input  wire logic       serial_in_addr_bit1_pin,
  input  wire logic       serial_out_shared_data_pin_in,
  output logic            serial_out_shared_data_pin_out,
  output logic            serial_out_shared_data_pin_oe,
  input  wire logic       five_volt_supply_ok,
  input  wire logic       logic_supply_ok,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_addr_valid,
  output logic            half_duplex_select
);
  hsp_sync_if #(.W(SYNC_W)) pins ();

  assign pins.raw = {logic_supply_ok, five_volt_supply_ok, iface_sel_pin,
                     serial_out_shared_data_pin_in, serial_in_addr_bit1_pin,
                     select_addr_bit0_pin, sclk_pin};

  hsp_sync #(.W(SYNC_W)) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .pins    (pins)
  );

  logic        sclk_s;
  logic        cs_s;
  logic        sdi_s;
  logic        sda_s;
  logic        i2c_sel;
  logic        sclk_q;
  logic        sda_q;
  logic        clk_rise;
  logic        clk_fall;
  logic        rd_cap;

  assign sclk_s   = pins.synced[IX_SCLK];
  assign cs_s     = pins.synced[IX_CS];
  assign sdi_s    = pins.synced[IX_SDI];
  assign sda_s    = pins.synced[IX_SDA];
  assign i2c_sel  = pins.synced[IX_SEL];                                   // RQ1
  assign clk_rise = sclk_s & ~sclk_q;                                      // RQ3 RQ11
  assign clk_fall = ~sclk_s & sclk_q;                                      // RQ3 RQ11

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      sda_q  <= 1'b1;
    end else if (clk_en) begin
      sclk_q <= sclk_s;
      sda_q  <= sda_s;
    end
  end

  // SPI side
  logic        spi_active;
  logic        spi_in;
  logic [4:0]  spi_cnt;
  logic [7:0]  spi_sh;
  logic [7:0]  spi_tx;
  logic        spi_rw;
  logic [7:0]  spi_byte;
  logic        spi_cmd;
  logic        spi_wr;
  logic        spi_oe;

  // Select pin doubles as strap in I2C mode and is never read as SS there
  assign spi_active = ~i2c_sel & ~cs_s & pins.synced[IX_FIVE_OK]
                      & pins.synced[IX_LOGIC_OK];                          // RQ6
  assign spi_in     = half_duplex_select ? sda_s : sdi_s;                  // RQ7
  assign spi_byte   = {spi_sh[6:0], spi_in};
  assign spi_cmd    = spi_active & clk_rise & (spi_cnt == SPI_CMD_LAST);   // RQ19
  assign spi_wr     = spi_active & clk_rise & (spi_cnt == SPI_DAT_LAST)
                      & (spi_rw != RW_READ);                               // RQ9

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spi_cnt <= '0;
      spi_sh  <= '0;
      spi_rw  <= 1'b0;
    end else if (clk_en) begin
      if (!spi_active) begin
        spi_cnt <= '0;
        spi_sh  <= '0;
      end else if (clk_rise) begin                                         // RQ5
        spi_sh <= spi_byte;
        if (spi_cnt != SPI_FRAME)
          spi_cnt <= spi_cnt + 5'h01;
        if (spi_cmd)
          spi_rw <= spi_byte[7];
      end
    end
  end

  // Read data shifts out MSB first, changing on falling edges
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spi_tx <= '0;
    end else if (clk_en) begin
      if (!spi_active)
        spi_tx <= '0;
      else if (rd_cap)
        spi_tx <= reg_rdata;
      else if (clk_fall && spi_cnt > SPI_CMD_BITS)
        spi_tx <= {spi_tx[6:0], 1'b0};
    end
  end

  // Half duplex: pin is ours only for the eight read-data clocks
  always_comb begin
    if (!half_duplex_select)
      spi_oe = spi_active;                                                 // RQ7
    else
      spi_oe = spi_active & (spi_rw == RW_READ) & (spi_cnt >= SPI_CMD_BITS)
               & (spi_cnt < SPI_FRAME);                                    // RQ10
  end

  // I2C side
  hsp_i2c_st_t st;
  logic [3:0]  i_cnt;
  logic [7:0]  i_sh;
  logic [7:0]  i_tx;
  logic [1:0]  phase;
  logic [1:0]  wcount;
  logic        i_rw;
  logic        i_ack;
  logic        i_start;
  logic        i_stop;
  logic        i_byte_end;
  logic        i_match;
  logic        i_aload;
  logic        i_wr;
  logic        i_rd;
  logic        i_incr;
  logic        i_oe;

  assign i_start    = i2c_sel & sclk_s & sclk_q & sda_q & ~sda_s;
  assign i_stop     = i2c_sel & sclk_s & sclk_q & ~sda_q & sda_s;
  assign i_byte_end = (st == I_RX) & clk_fall & (i_cnt == I2C_BYTE);
  assign i_match    = (i_sh[7:1] == {I2C_ADDR_HI, sdi_s, cs_s});          // RQ13
  assign i_aload    = (st == I_RX) & clk_rise & (i_cnt == I2C_BIT_LAST)
                      & (phase == PH_REG);
  assign i_wr       = i_byte_end & (phase == PH_DATA) & (wcount < I2C_MAX_WR);
  assign i_rd       = (i_byte_end & (phase == PH_DEV) & i_match & (i_sh[0] == RW_READ))
                      | ((st == I_MACK) & clk_rise & ~sda_s);              // RQ12
  assign i_incr     = ((st == I_TX) & clk_fall & (i_cnt == I2C_BIT_LAST))
                      | ((st == I_ACK) & clk_fall & i_ack & ~i_rw & (phase == PH_DATA));
  assign i_oe       = ((st == I_ACK) & i_ack) | ((st == I_TX) & ~i_tx[7]);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st     <= I_IDLE;
      i_cnt  <= '0;
      i_sh   <= '0;
      phase  <= PH_DEV;
      wcount <= '0;
      i_rw   <= 1'b0;
      i_ack  <= 1'b0;
    end else if (clk_en) begin
      if (!i2c_sel || i_stop) begin
        st <= I_IDLE;
      end else if (i_start) begin                                          // RQ15
        st     <= I_RX;
        i_cnt  <= '0;
        phase  <= PH_DEV;
        wcount <= '0;
      end else begin
        unique case (st)
          I_IDLE: begin
          end
          I_RX: begin
            if (clk_rise) begin
              i_sh  <= {i_sh[6:0], sda_s};
              i_cnt <= i_cnt + 4'h1;
            end else if (i_byte_end) begin
              st    <= I_ACK;
              i_cnt <= '0;
              if (phase == PH_DEV) begin
                i_ack <= i_match;                                          // RQ14
                i_rw  <= i_sh[0];
              end else if (phase == PH_REG) begin
                i_ack <= reg_addr_valid;                                   // RQ17
              end else begin
                i_ack <= (wcount < I2C_MAX_WR);                            // RQ18
                if (wcount < I2C_MAX_WR)
                  wcount <= wcount + 2'h1;
              end
            end
          end
          I_ACK: begin
            if (clk_fall) begin
              i_cnt <= '0;
              if (!i_ack)
                st <= I_IDLE;
              else if (i_rw == RW_READ)
                st <= I_TX;
              else
                st <= I_RX;                                                // RQ16
              if (i_rw == RW_READ || phase != PH_DEV)
                phase <= PH_DATA;
              else
                phase <= PH_REG;
            end
          end
          I_TX: begin
            if (clk_fall) begin
              i_cnt <= i_cnt + 4'h1;
              if (i_cnt == I2C_BIT_LAST)
                st <= I_MACK;
            end
          end
          I_MACK: begin
            if (clk_rise)
              i_ack <= ~sda_s;
            else if (clk_fall) begin
              i_cnt <= '0;
              st    <= i_ack ? I_TX : I_IDLE;                              // RQ12
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      i_tx <= 8'hff;
    else if (clk_en) begin
      if (rd_cap && i2c_sel)
        i_tx <= reg_rdata;
      else if (st == I_TX && clk_fall)
        i_tx <= {i_tx[6:0], 1'b1};
    end
  end

  // Register access, shared by both interfaces
  logic       wr_ev;
  logic [7:0] wr_byte;

  assign wr_ev   = spi_wr | i_wr;
  assign wr_byte = i2c_sel ? i_sh : spi_byte;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_addr  <= '0;
      reg_wdata <= '0;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      rd_cap    <= 1'b0;
    end else if (clk_en) begin
      rd_cap <= reg_rd;
      reg_wr <= wr_ev;                                                     // RQ2
      reg_rd <= i_rd | (spi_cmd & (spi_byte[7] == RW_READ));               // RQ2
      if (wr_ev)
        reg_wdata <= wr_byte;
      if (spi_cmd)
        reg_addr <= {1'b0, spi_byte[6:0]};
      else if (i_aload)
        reg_addr <= {i_sh[6:0], sda_s};
      else if (i_incr)
        reg_addr <= reg_addr + 8'h01;                                      // RQ12
    end
  end

  // Shadow of the mode register's half-duplex bit; cleared by reset or by a mode register write with the bit low
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      half_duplex_select <= 1'b0;                                          // RQ4
    else if (clk_en && wr_ev && !i_incr && reg_addr == MODE_ADDR && !spi_cmd)
      half_duplex_select <= wr_byte[MODE_HDX_BIT];                         // RQ4
  end

  // I2C drives only low; SPI drives both levels
  assign serial_out_shared_data_pin_out = i2c_sel ? 1'b0 : spi_tx[7];
  assign serial_out_shared_data_pin_oe  = i2c_sel ? i_oe : spi_oe;         // RQ20
endmodule

/* logic/hsp_pkg.sv */
// Constants and types shared by the host serial register port
package hsp_pkg;
  localparam int          SYNC_W       = 7;
  localparam int          IX_SCLK      = 0;
  localparam int          IX_CS        = 1;
  localparam int          IX_SDI       = 2;
  localparam int          IX_SDA       = 3;
  localparam int          IX_SEL       = 4;
  localparam int          IX_FIVE_OK   = 5;
  localparam int          IX_LOGIC_OK  = 6;
  localparam int          SYS_CLK_HZ   = 10_000_000;
  localparam int          SPI_MAX_HZ   = 12_000_000;
  localparam int          I2C_MAX_HZ   = 1_000_000;
  localparam logic [4:0]  I2C_ADDR_HI  = 5'h0d;
  localparam logic [7:0]  MODE_ADDR    = 8'h04;
  localparam int          MODE_HDX_BIT = 6;
  localparam logic [4:0]  SPI_CMD_LAST = 5'h07;
  localparam logic [4:0]  SPI_CMD_BITS = 5'h08;
  localparam logic [4:0]  SPI_DAT_LAST = 5'h0f;
  localparam logic [4:0]  SPI_FRAME    = 5'h10;
  localparam logic [3:0]  I2C_BIT_LAST = 4'h7;
  localparam logic [3:0]  I2C_BYTE     = 4'h8;
  localparam logic [1:0]  PH_DEV       = 2'h0;
  localparam logic [1:0]  PH_REG       = 2'h1;
  localparam logic [1:0]  PH_DATA      = 2'h2;
  localparam logic [1:0]  I2C_MAX_WR   = 2'h2;
  localparam logic        RW_READ      = 1'b1;

  typedef enum logic [4:0] {
    I_IDLE = 5'h01,
    I_RX   = 5'h02,
    I_ACK  = 5'h04,
    I_TX   = 5'h08,
    I_MACK = 5'h10
  } hsp_i2c_st_t;
endpackage

/* logic/hsp_sync_if.sv */
// Raw and synchronised pin levels between the port and its synchroniser
`timescale 1ns/100ps
interface hsp_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface

/* logic/hsp_sync.sv */
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module hsp_sync #(parameter int W = 1) (
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  input  wire logic  clk_en,
  hsp_sync_if.sync   pins
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta   <= '0;
      stable <= '0;
    end else if (clk_en) begin
      meta   <= pins.raw;
      stable <= meta;
    end
  end

  assign pins.synced = stable;
endmodule

/* tb/hsp_host.sv */
// Host controller model driving SPI or I2C frames on the port pins
`timescale 1ns/100ps
module hsp_host (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  output logic      sda_low
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Eight cycles a bit keeps each clock phase above the sampler's minimum
  task automatic spi(input logic [15:0] tx, input logic hdx, output logic [7:0] rx);
    cs_n <= 1'b0;
    wt(4);
    for (int i = 15; i >= 0; i--) begin
      mosi <= hdx ? 1'b0 : tx[i];
      sda_low <= hdx && (i > 7 || !tx[15]) && !tx[i];
      wt(4);
      sclk <= 1'b1;
      if (i < 8) rx[i] = sda;
      wt(4);
      sclk <= 1'b0;
    end
    wt(4);
    cs_n <= 1'b1;
    sda_low <= 1'b0;
    wt(8);
  endtask
  task automatic i2c_start();
    sda_low <= 1'b0;
    wt(4);
    sclk <= 1'b1;
    wt(4);
    sda_low <= 1'b1;
    wt(4);
    sclk <= 1'b0;
    wt(2);
  endtask
  task automatic i2c_stop();
    sda_low <= 1'b1;
    wt(4);
    sclk <= 1'b1;
    wt(4);
    sda_low <= 1'b0;
    wt(4);
  endtask
  // Data held two cycles past the fall so it never races the clock edge
  task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !tx[i];
      wt(2);
      sclk <= 1'b1;
      wt(2);
      rx[i] = sda;
      wt(2);
      sclk <= 1'b0;
      wt(2);
    end
  endtask
endmodule

/* tb/hsp_port_sva.sv */
// Assertions on the host serial register port pins and register strobes
`timescale 1ns/100ps
module hsp_port_sva
  import hsp_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       iface_sel_pin,
  input wire logic       select_addr_bit0_pin,
  input wire logic       serial_out_shared_data_pin_out,
  input wire logic       serial_out_shared_data_pin_oe,
  input wire logic       five_volt_supply_ok,
  input wire logic       logic_supply_ok,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       reg_addr_valid,
  input wire logic       half_duplex_select
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  a_wr_one_cycle: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  a_rd_one_cycle: assert property (reg_rd |=> !reg_rd)
    else $error("read strobe longer than one cycle");
  a_spi_supply_dead: assert property ((!iface_sel_pin && !(five_volt_supply_ok &&
    logic_supply_ok)) [*5] |-> !reg_wr && !reg_rd && !serial_out_shared_data_pin_oe)
    else $error("port active with a supply low");
  a_spi_idle_quiet: assert property ((!iface_sel_pin && select_addr_bit0_pin) [*5]
    |-> !serial_out_shared_data_pin_oe)
    else $error("shared pin driven while deselected");
  a_hdx_follows_wr: assert property (reg_wr && reg_addr == MODE_ADDR |-> ##[0:1]
    half_duplex_select == reg_wdata[MODE_HDX_BIT])
    else $error("half duplex bit not taken from mode write");
  a_hdx_only_by_wr: assert property ($changed(half_duplex_select) |->
    $past(reg_wr && reg_addr == MODE_ADDR) || (reg_wr && reg_addr == MODE_ADDR))
    else $error("half duplex bit changed without mode write");
  a_i2c_drive_low: assert property (iface_sel_pin [*4] ##0 serial_out_shared_data_pin_oe
    |-> !serial_out_shared_data_pin_out)
    else $error("data line driven high in I2C");
  a_i2c_valid_wr: assert property (iface_sel_pin && reg_wr |-> reg_addr_valid)
    else $error("I2C write to unmapped register");
endmodule
bind hsp_port hsp_port_sva u_sva (.sys_clk, .sys_rst, .iface_sel_pin, .select_addr_bit0_pin,
  .serial_out_shared_data_pin_out, .serial_out_shared_data_pin_oe, .five_volt_supply_ok,
  .logic_supply_ok, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_addr_valid,
  .half_duplex_select);

/* tb/testbench.sv */
// Self-checking bench for the host serial register port
`timescale 1ns/100ps
module testbench
  import hsp_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       iface_sel_pin = 1'b0;
  logic       five_volt_supply_ok = 1'b1;
  logic       logic_supply_ok = 1'b1;
  logic       out_w, oe_w, reg_wr, reg_rd, half_duplex_select;
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] reg_rdata = 8'h00;
  logic [7:0] mem [16];
  wire        sclk, cs_n, mosi, sda_low;
  // Pull-up on the shared line; either party may only pull it low or drive when enabled
  wire        sda = !sda_low && (!oe_w || out_w);
  wire        reg_addr_valid = reg_addr < 8'h0d && reg_addr != 8'h0b;
  int         mismatches = 0;
  int         num_checks = 0;
  always #50 sys_clk = !sys_clk;
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(posedge sys_clk) begin
    if (reg_rd) reg_rdata <= mem[reg_addr[3:0]];
    if (reg_wr) mem[reg_addr[3:0]] <= reg_wdata;
  end
  hsp_host u_host (.sys_clk, .sda, .sclk, .cs_n, .mosi, .sda_low);
  hsp_port u_dut (.sys_clk, .sys_rst, .clk_en(1'b1), .iface_sel_pin, .sclk_pin(sclk),
    .select_addr_bit0_pin(cs_n), .serial_in_addr_bit1_pin(mosi),
    .serial_out_shared_data_pin_in(sda), .serial_out_shared_data_pin_out(out_w),
    .serial_out_shared_data_pin_oe(oe_w), .five_volt_supply_ok, .logic_supply_ok,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_addr_valid, .half_duplex_select);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic ib(input logic [7:0] b, input logic nack);
    logic [8:0] a;
    u_host.i2c_byte({b, 1'b1}, a);
    chk({7'h00, a[0]}, {7'h00, nack});
  endtask
  task automatic ir(input logic [7:0] exp, input logic last);
    logic [8:0] a;
    u_host.i2c_byte({8'hff, last}, a);
    chk(a[8:1], exp);
  endtask
  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
  initial begin
    logic [7:0] r;
    logic [1:0] st;
    logic [6:0] dev;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    u_host.wt(4);
    chk({7'h00, half_duplex_select}, 8'h00);
    u_host.spi({8'h05, 8'ha5}, 1'b0, r);
    u_host.spi({8'h85, 8'h00}, 1'b0, r);
    chk(r, 8'ha5);
    for (int k = 0; k < 2; k++) begin
      five_volt_supply_ok <= k[0];
      logic_supply_ok <= !k[0];
      u_host.wt(8);
      u_host.spi({8'h06, 8'h3c}, 1'b0, r);
      five_volt_supply_ok <= 1'b1;
      logic_supply_ok <= 1'b1;
      u_host.wt(8);
      u_host.spi({8'h86, 8'h00}, 1'b0, r);
      chk(r, 8'h00);
    end
    u_host.spi({MODE_ADDR, 8'(1 << MODE_HDX_BIT)}, 1'b0, r);
    chk({7'h00, half_duplex_select}, 8'h01);
    u_host.spi({8'h85, 8'h00}, 1'b1, r);
    chk(r, 8'ha5);
    u_host.spi({8'h07, 8'h5a}, 1'b1, r);
    u_host.spi({8'h87, 8'h00}, 1'b1, r);
    chk(r, 8'h5a);
    iface_sel_pin <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      st = 2'(s);
      u_host.cs_n <= st[0];
      u_host.mosi <= st[1];
      dev = {I2C_ADDR_HI, st};
      u_host.wt(8);
      u_host.i2c_start();
      ib({I2C_ADDR_HI, ~st, 1'b0}, 1'b1);
      u_host.i2c_stop();
      u_host.i2c_start();
      ib({dev, 1'b0}, 1'b0);
      ib(8'h0f, 1'b1);
      u_host.i2c_stop();
    end
    u_host.i2c_start();
    ib({dev, 1'b0}, 1'b0);
    ib(8'h08, 1'b0);
    ib(8'h11, 1'b0);
    ib(8'h22, 1'b0);
    ib(8'h33, 1'b1);
    u_host.i2c_stop();
    u_host.i2c_start();
    ib({dev, 1'b0}, 1'b0);
    ib(8'h07, 1'b0);
    u_host.i2c_start();
    ib({dev, RW_READ}, 1'b0);
    ir(8'h5a, 1'b0);
    ir(8'h11, 1'b0);
    ir(8'h22, 1'b0);
    ir(8'h00, 1'b1);
    u_host.i2c_stop();
    final_report();
  end
endmodule
